// file: dv/pco_clock_out_props.sv
// checker for the programmable clock output block
// assumes one clock domain and a synchronous active-low reset
module pco_clock_out_props (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic timer0_ext_pin_i,
  input wire logic timer1_ext_pin_i,
  input wire logic timer1_input_o,
  input wire logic master_clock_out_pin_o,
  input wire logic alt_master_clock_out_pin_o,
  input wire logic timer0_clock_out_o,
  input wire logic timer0_clock_out_oe_n_o,
  input wire logic timer0_overflow_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // shadow of the select field
  logic [1:0] sel_q;
  logic alt_q;
  logic [2:0] age_q;
  wire sel_wr = reg_write_i && reg_addr_i == pco_pkg::ADDR_CLOCK_DIVISION;
  wire mpin = alt_q ? alt_master_clock_out_pin_o : master_clock_out_pin_o;
  wire settled = age_q == 3'h7;
  // cycles since the division register was last written, saturating
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || sel_wr) age_q <= 3'h0;
    else if (!settled) age_q <= age_q + 3'h1;
    if (!reset_n_i) {sel_q, alt_q} <= 3'h0;
    else if (sel_wr) {sel_q, alt_q} <= {reg_wdata_i[7:6], reg_wdata_i[3]};
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_hold_two;
    mpin ##1 !mpin;
  endsequence
  a_mclk_silent: assert property (settled && sel_q == 2'h0 |->
    !master_clock_out_pin_o && !alt_master_clock_out_pin_o)
    else $error("master output active while off");
  a_mclk_full: assert property (settled && sel_q inside {2'h1, 2'h2}
    |=> mpin != $past(mpin)) else $error("fast master output stuck");
  a_mclk_quarter: assert property (settled && sel_q == 2'h3 && $rose(mpin)
    |=> s_hold_two) else $error("quarter master output wrong shape");
  a_pin_exclusive: assert property (!(master_clock_out_pin_o &&
    alt_master_clock_out_pin_o)) else $error("both master pins high");
  a_sel_readback: assert property (reg_read_i &&
    reg_addr_i == pco_pkg::ADDR_CLOCK_DIVISION |=> reg_rdata_o[7:6] == sel_q)
    else $error("select field read back wrong");
  a_t0_enable_bit: assert property (reg_write_i &&
    reg_addr_i == pco_pkg::ADDR_CLKOUT_IRQEN |=>
    timer0_clock_out_oe_n_o == !$past(reg_wdata_i[0]))
    else $error("timer output enable not from bit 0");
  a_t0_gated: assert property (timer0_clock_out_oe_n_o |->
    !timer0_clock_out_o) else $error("timer output while disabled");
  a_t1_reroute: assert property (timer1_input_o ==
    (timer1_ext_pin_i && timer0_clock_out_oe_n_o))
    else $error("timer 1 input not rerouted");
  a_reset_quiet: assert property ($rose(reset_n_i) |->
    !mpin && !master_clock_out_pin_o && !timer0_clock_out_o &&
    timer0_clock_out_oe_n_o && !timer0_overflow_o)
    else $error("outputs active after reset");
endmodule : pco_clock_out_props

bind pco_clock_out pco_clock_out_props u_props (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
  .reg_rdata_o(reg_rdata_o), .timer0_ext_pin_i(timer0_ext_pin_i),
  .timer1_ext_pin_i(timer1_ext_pin_i), .timer1_input_o(timer1_input_o),
  .master_clock_out_pin_o(master_clock_out_pin_o),
  .alt_master_clock_out_pin_o(alt_master_clock_out_pin_o),
  .timer0_clock_out_o(timer0_clock_out_o),
  .timer0_clock_out_oe_n_o(timer0_clock_out_oe_n_o),
  .timer0_overflow_o(timer0_overflow_o));

// file: dv/pco_pin_meter.sv
// external circuit fed by a clock output pin: measures its toggling
// assumes the pin is sampled on the system clock
module pco_pin_meter (
  input wire logic clk_sys_i,
  input wire logic pin_i,
  output int gap_o,
  output int edges_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q;
  int run_q = 0;
  // ==========================================================
  // cycles between level changes and count of changes
  always_ff @(posedge clk_sys_i) begin
    last_q <= pin_i;
    run_q <= (pin_i != last_q) ? 1 : run_q + 1;
    if (pin_i != last_q) begin
      gap_o <= run_q;
      edges_o <= edges_o + 1;
    end
  end
endmodule : pco_pin_meter

// file: dv/tb_pco_clock_out.sv
// testbench for the programmable clock output block
// assumes design, checker and pin meter are compiled before it
module tb_pco_clock_out;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] div, aux, mode, th, tl; int mgap;} pco_row_t;
  logic clk_sys_i = 1'b0, reset_n_i = 1'b0, reg_write_i = 1'b0;
  logic reg_read_i = 1'b0, t0_pin = 1'b0, t1_pin = 1'b1;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic t1_in, mclk, alt, t0_out, oe_n, t0_ovf;
  int m_gap, m_edges, t_gap, t_edges, e0, got, errors = 0, n_tests = 0;
  int a_gap, a_edges;
  pco_row_t rows[4] = '{
    '{8'h00, 8'h80, 8'h00, 8'hFF, 8'hFE, 0},
    '{8'h40, 8'h80, 8'h02, 8'hFD, 8'hFD, 1},
    '{8'h80, 8'h00, 8'h00, 8'hFF, 8'hFF, 1},
    '{8'hC0, 8'h80, 8'h00, 8'hFE, 8'hFF, 2}};
  // ==========================================================
  // design and far-side meters
  pco_clock_out dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .timer0_ext_pin_i(t0_pin),
    .timer1_ext_pin_i(t1_pin), .timer1_input_o(t1_in),
    .master_clock_out_pin_o(mclk), .alt_master_clock_out_pin_o(alt),
    .timer0_clock_out_o(t0_out), .timer0_clock_out_oe_n_o(oe_n),
    .timer0_overflow_o(t0_ovf));
  pco_pin_meter u_mm (.clk_sys_i(clk_sys_i), .pin_i(mclk),
    .gap_o(m_gap), .edges_o(m_edges));
  pco_pin_meter u_tm (.clk_sys_i(clk_sys_i), .pin_i(t0_out),
    .gap_o(t_gap), .edges_o(t_edges));
  pco_pin_meter u_am (.clk_sys_i(clk_sys_i), .pin_i(alt),
    .gap_o(a_gap), .edges_o(a_edges));
  // clock at 100 MHz
  always #5 clk_sys_i = ~clk_sys_i;
  // ==========================================================
  // tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_write_i <= 1'b0;
    #1;
  endtask : wr
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk8
  task automatic chki(input string n, input int e, input int g);
    n_tests++;
    if (g != e) begin
      errors++;
      $display("ERROR %s expected %0d seen %0d", n, e, g);
    end
  endtask : chki
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_read_i <= 1'b0;
    #1 chk8(n, e, reg_rdata_o);
  endtask : rd
  // pulses on the external count pin, four clocks each
  task automatic pulses(input int n);
    @(posedge clk_sys_i);
    repeat (n) begin
      t0_pin <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      t0_pin <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
    end
  endtask : pulses
  // toggle spacing of the timer output in system clocks
  function automatic int exp_t(input pco_row_t r);
    int n;
    n = (r.mode == 8'h02) ? 256 - r.th : 65536 - {r.th, r.tl};
    return r.aux[7] ? n : 12 * n;
  endfunction : exp_t
  task automatic final_report;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  // ==========================================================
  // watchdog
  initial begin
    #1ms;
    errors++;
    final_report();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    #1 chk8("pins", 8'h01, {4'h0, mclk, alt, t0_out, oe_n});
    rd(pco_pkg::ADDR_CLOCK_DIVISION, 8'h00, "div");
    rd(pco_pkg::ADDR_CLKOUT_IRQEN, 8'h00, "enable");
    wr(8'hFF, 8'h5A);
    rd(8'hFF, 8'h00, "unmapped");
    chk8("reroute off", 8'h03, {6'h0, oe_n, t1_in});
    foreach (rows[i]) begin
      wr(pco_pkg::ADDR_RUN_CTRL, 8'h00);
      wr(pco_pkg::ADDR_CLOCK_DIVISION, rows[i].div);
      wr(pco_pkg::ADDR_AUX, rows[i].aux);
      wr(pco_pkg::ADDR_TIMER_MODE, rows[i].mode);
      wr(pco_pkg::ADDR_COUNT_LOW, rows[i].tl);
      wr(pco_pkg::ADDR_COUNT_HIGH, rows[i].th);
      wr(pco_pkg::ADDR_RUN_CTRL, 8'h10);
      wr(pco_pkg::ADDR_CLKOUT_IRQEN, 8'h01);
      chk8("reroute on", 8'h00, {6'h0, oe_n, t1_in});
      rd(pco_pkg::ADDR_CLOCK_DIVISION, rows[i].div, "div");
      e0 = m_edges;
      repeat (3 * exp_t(rows[i]) + 20) @(posedge clk_sys_i);
      got = (rows[i].mgap == 0) ? m_edges - e0 : m_gap;
      chki("master gap", rows[i].mgap, got);
      chki("timer gap", exp_t(rows[i]), t_gap);
    end
    wr(pco_pkg::ADDR_RUN_CTRL, 8'h00);
    wr(pco_pkg::ADDR_TIMER_MODE, 8'h06);
    wr(pco_pkg::ADDR_COUNT_LOW, 8'hFE);
    wr(pco_pkg::ADDR_COUNT_HIGH, 8'hFE);
    wr(pco_pkg::ADDR_RUN_CTRL, 8'h10);
    e0 = t_edges;
    repeat (100) @(posedge clk_sys_i);
    chki("idle edges", 0, t_edges - e0);
    pulses(40);
    chki("pulse gap", 8, t_gap);
    // reload byte rewritten while the timer runs
    wr(pco_pkg::ADDR_COUNT_HIGH, 8'hFC);
    pulses(40);
    chki("reload gap", 16, t_gap);
    chk8("ovf pin", 8'h01, {7'h0, t0_ovf});
    rd(pco_pkg::ADDR_RUN_CTRL, 8'h30, "run ctrl");
    wr(pco_pkg::ADDR_RUN_CTRL, 8'h00);
    chk8("ovf clear", 8'h00, {7'h0, t0_ovf});
    wr(pco_pkg::ADDR_CLOCK_DIVISION, 8'hC8);
    repeat (4) @(posedge clk_sys_i);
    e0 = m_edges;
    repeat (20) @(posedge clk_sys_i);
    chki("main edges", 0, m_edges - e0);
    chki("alt gap", 2, a_gap);
    rd(pco_pkg::ADDR_CLOCK_DIVISION, 8'hC8, "alt sel");
    // reset in mid-run returns every output to quiet
    @(posedge clk_sys_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    #1 chk8("pins rst", 8'h01, {4'h0, mclk, alt, t0_out, oe_n});
    rd(pco_pkg::ADDR_CLOCK_DIVISION, 8'h00, "div rst");
    @(posedge clk_sys_i);
    t1_pin <= 1'b0;
    #1 chk8("reroute pass", 8'h02, {6'h0, oe_n, t1_in});
    final_report();
  end
endmodule : tb_pco_clock_out

// file: src/pco_clock_out.sv
// programmable clock output: master clock divider and timer 0 output
// assumes synchronous register port, read data one cycle after strobe
// Function
// - select 00 drives no master clock
// - select 01 outputs undivided master clock
// - select 10 outputs master clock over two
// - select 11 outputs master clock over four
// - select field is top bits at 97H
// - divided clock is the selected master clock
// - output on main pin, alternate pin optional
// - bit 0 at 8FH enables timer output
// - enable reassigns timer 1 input pin
// - output toggles on each timer overflow
// - prescale set counts every system clock
// - prescale clear counts every twelve clocks
// - select 0 counts internal clock
// - select 1 counts external pin pulses
// - 8-bit mode reloads low from high
// - 16-bit mode reloads from hidden registers
module pco_clock_out (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  input wire logic timer0_ext_pin_i,
  input wire logic timer1_ext_pin_i,
  output logic timer1_input_o,
  output logic master_clock_out_pin_o,
  output logic alt_master_clock_out_pin_o,
  output logic timer0_clock_out_o,
  output logic timer0_clock_out_oe_n_o,
  output logic timer0_overflow_o
);

  // ==========================================================
  // register storage
  logic [7:0] clock_division_q;
  logic [7:0] clock_out_irq_enable_q;
  logic [7:0] aux_register_q;
  logic [7:0] timer_mode_register_q;
  logic timer0_run_q;
  logic timer0_ovf_flag_q;
  logic [7:0] timer0_count_low_q;
  logic [7:0] timer0_count_high_q;
  logic [7:0] timer0_reload_low_q;
  logic [7:0] timer0_reload_high_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // ==========================================================
  // address decode
  wire sel_div = reg_addr_i == pco_pkg::ADDR_CLOCK_DIVISION;
  wire sel_irqen = reg_addr_i == pco_pkg::ADDR_CLKOUT_IRQEN;
  wire sel_aux = reg_addr_i == pco_pkg::ADDR_AUX;
  wire sel_timer_mode_register = reg_addr_i == pco_pkg::ADDR_TIMER_MODE;
  wire sel_tl = reg_addr_i == pco_pkg::ADDR_COUNT_LOW;
  wire sel_th = reg_addr_i == pco_pkg::ADDR_COUNT_HIGH;
  wire sel_run = reg_addr_i == pco_pkg::ADDR_RUN_CTRL;
  wire wr_div = reg_write_i && sel_div;
  wire wr_irqen = reg_write_i && sel_irqen;
  wire wr_aux = reg_write_i && sel_aux;
  wire wr_timer_mode_register = reg_write_i && sel_timer_mode_register;
  wire wr_tl = reg_write_i && sel_tl;
  wire wr_th = reg_write_i && sel_th;
  wire wr_run = reg_write_i && sel_run;

  // ==========================================================
  // control fields
  wire [1:0] mclk_sel = clock_division_q[7:pco_pkg::MCLK_SEL_LO_POS];
  wire mclk_alt = clock_division_q[pco_pkg::MCLK_ALT_POS];
  wire t0_clko_en = clock_out_irq_enable_q[pco_pkg::T0_CLKO_EN_POS];
  wire t0_fast = aux_register_q[pco_pkg::T0_PRESCALE_POS];
  wire t0_counter = timer_mode_register_q[pco_pkg::T0_CT_POS];
  wire [1:0] t0_mode = timer_mode_register_q[1:pco_pkg::T0_MODE_LO_POS];
  wire t0_mode8 = t0_mode == pco_pkg::T0_MODE_8_RELOAD;

  // ==========================================================
  // read mux
  always_comb begin
    rdata_d = 8'h00;
    if (sel_div) begin
      rdata_d = clock_division_q;
    end else if (sel_irqen) begin
      rdata_d = clock_out_irq_enable_q;
    end else if (sel_aux) begin
      rdata_d = aux_register_q;
    end else if (sel_timer_mode_register) begin
      rdata_d = timer_mode_register_q;
    end else if (sel_tl) begin
      rdata_d = timer0_count_low_q;
    end else if (sel_th) begin
      rdata_d = timer0_count_high_q;
    end else if (sel_run) begin
      rdata_d = {2'h0, timer0_ovf_flag_q, timer0_run_q, 4'h0};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rdata_q <= 8'h00;
    end else if (reg_read_i) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ==========================================================
  // software registers

  // master clock select, alternate pin and other division bits
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      clock_division_q <= pco_pkg::CLOCK_DIVISION_RST;
    end else if (wr_div) begin
      clock_division_q <= reg_wdata_i;
    end
  end

  // timer 0 clock output enable and interrupt enable bits
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      clock_out_irq_enable_q <= pco_pkg::CLKOUT_IRQEN_RST;
    end else if (wr_irqen) begin
      clock_out_irq_enable_q <= reg_wdata_i;
    end
  end

  // timer 0 prescale bypass and other auxiliary bits
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      aux_register_q <= pco_pkg::AUX_RST;
    end else if (wr_aux) begin
      aux_register_q <= reg_wdata_i;
    end
  end

  // timer 0 mode and counter select
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      timer_mode_register_q <= pco_pkg::TIMER_MODE_RST;
    end else if (wr_timer_mode_register) begin
      timer_mode_register_q <= reg_wdata_i;
    end
  end

  // timer 0 run bit
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      timer0_run_q <= 1'b0;
    end else if (wr_run) begin
      timer0_run_q <= reg_wdata_i[pco_pkg::T0_RUN_POS];
    end
  end

  // ==========================================================
  // master clock output
  logic mclk_div;

  // divides the system clock, which is the selected master clock
  pco_mclk_div u_mclk_div (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .sel_i(mclk_sel),
    .mclk_o(mclk_div)
  );

  // route to main pin or alternate pin
  assign master_clock_out_pin_o = mclk_alt ? 1'b0 : mclk_div;
  assign alt_master_clock_out_pin_o = mclk_alt ? mclk_div : 1'b0;

  // ==========================================================
  // count clock: prescaler and external edge
  logic [3:0] pre_q;
  logic ext_q;
  wire pre_tick = pre_q == pco_pkg::PRESCALE_LAST;
  wire int_tick = t0_fast ? 1'b1 : pre_tick;
  wire ext_tick = timer0_ext_pin_i && !ext_q; // rising edge
  wire cnt_tick = t0_counter ? ext_tick : int_tick;
  wire inc = timer0_run_q && cnt_tick;

  // prescaler runs free from reset, wraps after twelve clocks
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      pre_q <= 4'h0;
    end else begin
      pre_q <= pre_tick ? 4'h0 : pre_q + 4'h1;
    end
  end

  // external pin level of the last cycle, idle low after reset
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= timer0_ext_pin_i;
    end
  end

  // ==========================================================
  // timer 0 counter with auto reload
  wire [15:0] cnt16 = {timer0_count_high_q, timer0_count_low_q};
  wire [15:0] cnt16_inc = cnt16 + 16'h0001;
  wire [7:0] cnt8_inc = timer0_count_low_q + 8'h01;
  wire ovf16 = cnt16 == 16'hFFFF;
  wire ovf8 = timer0_count_low_q == 8'hFF;
  wire ovf = inc && (t0_mode8 ? ovf8 : ovf16);
  logic [7:0] timer0_count_low_d;
  logic [7:0] timer0_count_high_d;

  // count writes load the counter only while stopped; in 8-bit mode
  // the high byte is the reload value, so it stays writable
  wire load_low = wr_tl && !timer0_run_q;
  wire load_high = wr_th && (!timer0_run_q || t0_mode8);

  // one count step: 8-bit mode reloads low from high
  wire [7:0] step8_low = ovf8 ? timer0_count_high_q : cnt8_inc;
  // 16-bit mode copies the hidden reload pair on overflow
  wire [7:0] step16_low = ovf16 ? timer0_reload_low_q :
    cnt16_inc[7:0];
  wire [7:0] step16_high = ovf16 ? timer0_reload_high_q :
    cnt16_inc[15:8];
  wire [7:0] step_low = t0_mode8 ? step8_low : step16_low;
  wire [7:0] step_high = t0_mode8 ? timer0_count_high_q : step16_high;
  wire [7:0] run_low = inc ? step_low : timer0_count_low_q;
  wire [7:0] run_high = inc ? step_high : timer0_count_high_q;

  // a software load takes priority, no count tick is lost to a write
  assign timer0_count_low_d = load_low ? reg_wdata_i : run_low;
  assign timer0_count_high_d = load_high ? reg_wdata_i : run_high;

  // count bytes
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      timer0_count_low_q <= pco_pkg::COUNT_RST;
      timer0_count_high_q <= pco_pkg::COUNT_RST;
    end else begin
      timer0_count_low_q <= timer0_count_low_d;
      timer0_count_high_q <= timer0_count_high_d;
    end
  end

  // hidden reload pair, written by every count write
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      timer0_reload_low_q <= pco_pkg::COUNT_RST;
      timer0_reload_high_q <= pco_pkg::COUNT_RST;
    end else begin
      if (wr_tl) begin
        timer0_reload_low_q <= reg_wdata_i;
      end
      if (wr_th) begin
        timer0_reload_high_q <= reg_wdata_i;
      end
    end
  end

  // ==========================================================
  // overflow flag and clock output toggle
  logic t0_out_q;

  // output toggle, one change per overflow
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      t0_out_q <= 1'b0;
    end else if (ovf) begin
      t0_out_q <= ~t0_out_q;
    end
  end

  // sticky flag: a hardware set wins over a software clear
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      timer0_ovf_flag_q <= 1'b0;
    end else if (ovf) begin
      timer0_ovf_flag_q <= 1'b1;
    end else if (wr_run) begin
      timer0_ovf_flag_q <= reg_wdata_i[pco_pkg::T0_OVF_POS];
    end
  end

  assign timer0_overflow_o = timer0_ovf_flag_q;
  assign timer0_clock_out_o = t0_clko_en & t0_out_q;
  // pin taken from timer 1 input while enabled
  assign timer0_clock_out_oe_n_o = ~t0_clko_en;
  assign timer1_input_o = t0_clko_en ? 1'b0 : timer1_ext_pin_i;

endmodule : pco_clock_out

// file: src/pco_mclk_div.sv
// master clock divider for the master clock output pins
// assumes clk_sys_i is the selected master clock and the pin is
// regenerated as an enable-style level sampled at the output pad
module pco_mclk_div (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [1:0] sel_i,
  output logic mclk_o
);

  // ==========================================================
  // free divide chain
  logic [1:0] div_q;
  logic [1:0] div_d;
  logic mclk_q;
  logic mclk_d;
  logic full_phase_q;

  assign div_d = div_q + 2'h1;

  // output select from divider taps
  always_comb begin
    case (pco_pkg::pco_mclk_sel_t'(sel_i))
      pco_pkg::PCO_MCLK_OFF: mclk_d = 1'b0;
      pco_pkg::PCO_MCLK_DIV1: mclk_d = ~full_phase_q;
      pco_pkg::PCO_MCLK_DIV2: mclk_d = ~div_q[0];
      default: mclk_d = div_q[1];
    endcase
  end

  // divider and registered output
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      div_q <= 2'h0;
      mclk_q <= 1'b0;
      full_phase_q <= 1'b0;
    end else begin
      div_q <= div_d;
      mclk_q <= mclk_d;
      full_phase_q <= ~full_phase_q;
    end
  end

  // full rate stands as a toggle at the clock rate in this model
  assign mclk_o = mclk_q;

endmodule : pco_mclk_div

// file: src/pco_pkg.sv
// package of constants for the programmable clock output block
// assumes an 8-bit special-function register port and one 100 MHz clock
package pco_pkg;

  // ==========================================================
  // register addresses
  localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h8A;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_AUX = 8'h8E;
  localparam logic [7:0] ADDR_CLKOUT_IRQEN = 8'h8F;
  localparam logic [7:0] ADDR_CLOCK_DIVISION = 8'h97;
  localparam logic [7:0] ADDR_RUN_CTRL = 8'h88;

  // ==========================================================
  // field positions
  localparam int MCLK_SEL_LO_POS = 6;
  localparam int MCLK_ALT_POS = 3;
  localparam int T0_CLKO_EN_POS = 0;
  localparam int T0_PRESCALE_POS = 7;
  localparam int T0_CT_POS = 2;
  localparam int T0_MODE_LO_POS = 0;
  localparam int T0_RUN_POS = 4;
  localparam int T0_OVF_POS = 5;

  // ==========================================================
  // reset values
  localparam logic [7:0] CLOCK_DIVISION_RST = 8'h00;
  localparam logic [7:0] CLKOUT_IRQEN_RST = 8'h00;
  localparam logic [7:0] AUX_RST = 8'h00;
  localparam logic [7:0] TIMER_MODE_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;

  // ==========================================================
  // timer modes and counts
  localparam logic [1:0] T0_MODE_16_RELOAD = 2'h0;
  localparam logic [1:0] T0_MODE_8_RELOAD = 2'h2;
  localparam int PRESCALE_DIV = 12;
  localparam logic [3:0] PRESCALE_LAST = 4'hB;

  // master clock divider selections
  typedef enum logic [1:0] {
    PCO_MCLK_OFF = 2'h0,
    PCO_MCLK_DIV1 = 2'h1,
    PCO_MCLK_DIV2 = 2'h2,
    PCO_MCLK_DIV4 = 2'h3
  } pco_mclk_sel_t;

endpackage : pco_pkg
